/* exciter_drive_defines.svh */
// Register offsets, field positions, reset values and timing counts for the exciter control
`ifndef EXCITER_DRIVE_DEFINES_SVH
`define EXCITER_DRIVE_DEFINES_SVH
`define OFS_CONFIG 12'h000
`define OFS_GAIN 12'h004
`define OFS_STATUS 12'h008
`define OFS_MASK 12'h00C
`define OFS_LIVE 12'h010
`define CFG_RESET 32'h0000_0001
`define CLK_MHZ 125
`define SW_FREQ_KHZ 414
`define SW_PERIOD_CYC ((`CLK_MHZ * 1000) / `SW_FREQ_KHZ)
`define DEGLITCH_NS 5000
`define DEGLITCH_CYC ((`DEGLITCH_NS * `CLK_MHZ + 999) / 1000)
`define HOLDOFF_MS 2
`define HOLDOFF_CYC (`HOLDOFF_MS * `CLK_MHZ * 1000)
`define STARTUP_MASK_CYCLES 7
`define UPPER_SKIP_CYCLES 3
`define UPPER_RETRIES 3
`define ST_BOOST_OV 0
`define ST_CRIT_OV 1
`define ST_CRIT_UV 2
`define ST_ILIM_LO 3
`define ST_ILIM_HI 4
`define ST_HOLDOFF 5
`define ST_LEVEL 6
`define ST_WIDTH 7
`endif

/* exciter_drive_pkg.sv */
// Types shared by the exciter control logic
package exciter_drive_pkg;
   typedef enum logic [1:0] {
      BST_OFF = 2'b00,
      BST_RUN = 2'b01,
      BST_SKIP = 2'b10,
      BST_HOLD = 2'b11
   } boost_state_e;
   typedef logic [8:0] dac_word_t;
endpackage

/* exciter_drive_control.sv */
// Exciter path control: sine sequencing, boost switch supervision, diagnostics, APB registers
`timescale 1ns/1ps
`include "exciter_drive_defines.svh"

module exciter_drive_control #(
   parameter int HOLDOFF_CYCLES = `HOLDOFF_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic boost_ov_cmp,
   input wire logic boost_crit_ov_cmp,
   input wire logic boost_crit_uv_cmp,
   input wire logic ilim_lower_cmp,
   input wire logic ilim_upper_cmp,
   output logic boost_switch,
   output logic boost_enable,
   output logic [1:0] supply_voltage_select,
   output logic high_current_boost_select,
   output logic [1:0] exciter_level_select,
   output logic exciter_path_enable,
   output exciter_drive_pkg::dac_word_t dac_pos,
   output exciter_drive_pkg::dac_word_t dac_neg,
   output logic [2:0] preamp_gain_select,
   output logic [3:0] common_mode_offset_select,
   output logic preamp_monitor_enable,
   output logic internal_amp_enable,
   output logic fault_n,
   output logic irq
);
   import exciter_drive_pkg::*;

   localparam int NCMP = 5;
   localparam int DGW = 10;
   localparam int SWW = 9;
   localparam int HOW = 32;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and deglitch filters

   logic [NCMP-1:0] cmp_in;
   logic [NCMP-1:0] s1_r, s2_r, s3_r, s1_nxt, s2_nxt, s3_nxt;
   logic [NCMP-1:0] filt_r, filt_nxt;
   logic [DGW-1:0] dg_cnt_r [NCMP];
   logic [DGW-1:0] dg_cnt_nxt [NCMP];

   assign cmp_in = {ilim_upper_cmp, ilim_lower_cmp, boost_crit_uv_cmp, boost_crit_ov_cmp,
                    boost_ov_cmp};

   // Three stages; a change counts once stages two and three agree
   always_comb begin
      s1_nxt = cmp_in;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
   end

   // Each diagnostic must persist before the filtered level follows
   genvar gi;
   generate
      for (gi = 0; gi < NCMP; gi++) begin : g_dg
         always_comb begin
            dg_cnt_nxt[gi] = dg_cnt_r[gi];
            filt_nxt[gi] = filt_r[gi];
            if (s2_r[gi] != s3_r[gi] || s3_r[gi] == filt_r[gi]) begin
               dg_cnt_nxt[gi] = '0;
            end else if (dg_cnt_r[gi] == DGW'(`DEGLITCH_CYC - 1)) begin
               dg_cnt_nxt[gi] = '0;
               filt_nxt[gi] = s3_r[gi];
            end else begin
               dg_cnt_nxt[gi] = dg_cnt_r[gi] + DGW'(1);
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dg_cnt_r[gi] <= '0;
            end else if (clk_en) begin
               dg_cnt_r[gi] <= dg_cnt_nxt[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         filt_r <= '0;
      end else if (clk_en) begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         filt_r <= filt_nxt;
      end
   end

   wire ov_f = filt_r[0];
   wire crit_ov_f = filt_r[1];
   wire crit_uv_f = filt_r[2];
   wire ilo_f = filt_r[3];
   wire ihi_f = filt_r[4];

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers

   logic [31:0] cfg_r, cfg_nxt;
   logic [2:0] gain_r, gain_nxt;
   logic [`ST_WIDTH-1:0] status_r, status_nxt, mask_r, mask_nxt, live;
   logic [31:0] rdata_nxt;
   logic wr_en, rd_en, addr_ok;

   // Config fields: [1:0] supply, [2] high current, [4:3] level, [7:5] freq,
   // [11:8] offset, [12] external amp, [13] boost enable request
   assign supply_voltage_select = cfg_r[1:0];
   assign high_current_boost_select = cfg_r[2];
   assign exciter_level_select = cfg_r[4:3];
   assign common_mode_offset_select = cfg_r[11:8];
   assign preamp_gain_select = gain_r;

   // Level codes 01 and 10 are the only live settings
   assign exciter_path_enable = cfg_r[4] ^ cfg_r[3];
   assign preamp_monitor_enable = exciter_path_enable & cfg_r[12];
   assign internal_amp_enable = exciter_path_enable & ~cfg_r[12];

   ////////////////////////////////////////////////////////////////////////////////
   // Boost switch sequencer

   boost_state_e bst_r, bst_nxt;
   logic [SWW-1:0] sw_cnt_r, sw_cnt_nxt, sw_jit;
   logic [2:0] start_cnt_r, start_cnt_nxt;
   logic [1:0] skip_cnt_r, skip_cnt_nxt, retry_r, retry_nxt;
   logic [HOW-1:0] hold_cnt_r, hold_cnt_nxt;
   logic [3:0] lfsr_r, lfsr_nxt;
   logic cut_r, cut_nxt, bst_run_ok, cycle_end, lim_live;

   // Spread period: nominal plus a pseudo random step within ten percent
   assign sw_jit = SWW'(`SW_PERIOD_CYC - 32) + SWW'({lfsr_r, 2'b00});
   assign cycle_end = (sw_cnt_r >= sw_jit - SWW'(1));
   assign bst_run_ok = cfg_r[13] & ~crit_ov_f & ~crit_uv_f;
   assign lim_live = (start_cnt_r == 3'(`STARTUP_MASK_CYCLES));

   always_comb begin
      bst_nxt = bst_r;
      sw_cnt_nxt = cycle_end ? '0 : sw_cnt_r + SWW'(1);
      lfsr_nxt = cycle_end ? {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]} : lfsr_r;
      start_cnt_nxt = start_cnt_r;
      skip_cnt_nxt = skip_cnt_r;
      retry_nxt = retry_r;
      hold_cnt_nxt = hold_cnt_r;
      cut_nxt = cycle_end ? 1'b0 : cut_r;
      if (cycle_end && !lim_live && bst_r != BST_OFF) begin
         start_cnt_nxt = start_cnt_r + 3'(1);
      end
      case (bst_r)
         BST_OFF: begin
            start_cnt_nxt = '0;
            retry_nxt = '0;
            sw_cnt_nxt = '0;
            if (bst_run_ok) begin
               bst_nxt = BST_RUN;
            end
         end
         BST_RUN: begin
            if (!bst_run_ok) begin
               bst_nxt = BST_OFF;
            end else if (lim_live && ihi_f) begin
               if (retry_r == 2'(`UPPER_RETRIES)) begin
                  bst_nxt = BST_HOLD;
                  hold_cnt_nxt = '0;
               end else begin
                  bst_nxt = BST_SKIP;
                  skip_cnt_nxt = '0;
                  retry_nxt = retry_r + 2'(1);
               end
            end else if (lim_live && ilo_f && !cycle_end) begin
               cut_nxt = 1'b1;
            end else if (cycle_end && lim_live) begin
               retry_nxt = '0;
            end
         end
         BST_SKIP: begin
            if (!bst_run_ok) begin
               bst_nxt = BST_OFF;
            end else if (cycle_end) begin
               skip_cnt_nxt = skip_cnt_r + 2'(1);
               if (skip_cnt_r == 2'(`UPPER_SKIP_CYCLES - 1)) begin
                  bst_nxt = BST_RUN;
               end
            end
         end
         BST_HOLD: begin
            hold_cnt_nxt = hold_cnt_r + HOW'(1);
            if (!bst_run_ok) begin
               bst_nxt = BST_OFF;
            end else if (hold_cnt_r == HOW'(HOLDOFF_CYCLES - 1)) begin
               bst_nxt = BST_RUN;
               retry_nxt = '0;
            end
         end
         default: bst_nxt = BST_OFF;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bst_r <= BST_OFF;
         sw_cnt_r <= '0;
         lfsr_r <= 4'h1;
         start_cnt_r <= '0;
         skip_cnt_r <= '0;
         retry_r <= '0;
         hold_cnt_r <= '0;
         cut_r <= 1'b0;
      end else if (clk_en) begin
         bst_r <= bst_nxt;
         sw_cnt_r <= sw_cnt_nxt;
         lfsr_r <= lfsr_nxt;
         start_cnt_r <= start_cnt_nxt;
         skip_cnt_r <= skip_cnt_nxt;
         retry_r <= retry_nxt;
         hold_cnt_r <= hold_cnt_nxt;
         cut_r <= cut_nxt;
      end
   end

   // Low-side switch on for first half of each running cycle unless cut
   assign boost_enable = (bst_r != BST_OFF);
   assign boost_switch = (bst_r == BST_RUN) && !cut_r &&
                         (sw_cnt_r < (sw_jit >> 1)) &&
                         !(lim_live && (ilo_f || ihi_f));

   ////////////////////////////////////////////////////////////////////////////////
   // Sine table sequencer

   logic [5:0] phase_r, phase_nxt;
   logic [9:0] div_r, div_nxt, div_top;
   dac_word_t dac_pos_r, dac_pos_nxt;
   logic [7:0] quarter [16];

   // Quarter wave, 16 steps, scaled to 255
   assign quarter = '{8'h00, 8'h19, 8'h31, 8'h4A, 8'h61, 8'h78, 8'h8E, 8'hA2,
                      8'hB5, 8'hC5, 8'hD4, 8'hE0, 8'hEB, 8'hF4, 8'hFA, 8'hFE};

   // 64 samples per period; divider from 10 kHz (code 0) up to about 17.4 kHz (code 7)
   assign div_top = 10'(195) - 10'({cfg_r[7:5], 3'b000}) - 10'({cfg_r[7:5], 2'b00});

   always_comb begin
      logic [3:0] idx;
      logic [7:0] mag;
      idx = phase_r[4] ? ~phase_r[3:0] : phase_r[3:0];
      mag = quarter[idx];
      div_nxt = (div_r >= div_top) ? '0 : div_r + 10'(1);
      phase_nxt = (div_r >= div_top) ? phase_r + 6'(1) : phase_r;
      dac_pos_nxt = phase_r[5] ? 9'(9'h100 - {1'b0, mag}) : 9'(9'h100 + {1'b0, mag});
      if (!exciter_path_enable) begin
         div_nxt = '0;
         phase_nxt = '0;
         dac_pos_nxt = 9'h100;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= '0;
         div_r <= '0;
         dac_pos_r <= 9'h100;
      end else if (clk_en) begin
         phase_r <= phase_nxt;
         div_r <= div_nxt;
         dac_pos_r <= dac_pos_nxt;
      end
   end

   // Balanced pair around mid scale
   assign dac_pos = dac_pos_r;
   assign dac_neg = 9'(10'h200 - {1'b0, dac_pos_r});

   ////////////////////////////////////////////////////////////////////////////////
   // Fault status, interrupt and APB slave

   assign live = {~exciter_path_enable, bst_r == BST_HOLD, lim_live & ihi_f, lim_live & ilo_f,
                  crit_uv_f, crit_ov_f, ov_f};
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign addr_ok = paddr == `OFS_CONFIG || paddr == `OFS_GAIN || paddr == `OFS_STATUS ||
                    paddr == `OFS_MASK || paddr == `OFS_LIVE;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;

   // Read of status clears; new events win over the clear
   always_comb begin
      cfg_nxt = cfg_r;
      gain_nxt = gain_r;
      mask_nxt = mask_r;
      status_nxt = status_r;
      rdata_nxt = prdata;
      if (rd_en && paddr == `OFS_STATUS) begin
         status_nxt = '0;
      end
      status_nxt = status_nxt | live;
      if (wr_en) begin
         case (paddr)
            `OFS_CONFIG: cfg_nxt = {18'h0, pwdata[13:0]};
            `OFS_GAIN: gain_nxt = pwdata[2:0];
            `OFS_MASK: mask_nxt = pwdata[`ST_WIDTH-1:0];
            default: ;
         endcase
      end
      if (psel && !penable && !pwrite) begin
         case (paddr)
            `OFS_CONFIG: rdata_nxt = cfg_r;
            `OFS_GAIN: rdata_nxt = {29'h0, gain_r};
            `OFS_STATUS: rdata_nxt = {25'h0, status_r | live};
            `OFS_MASK: rdata_nxt = {25'h0, mask_r};
            `OFS_LIVE: rdata_nxt = {25'h0, live};
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= `CFG_RESET;
         gain_r <= '0;
         mask_r <= '0;
         status_r <= '0;
         prdata <= '0;
      end else if (clk_en) begin
         cfg_r <= cfg_nxt;
         gain_r <= gain_nxt;
         mask_r <= mask_nxt;
         status_r <= status_nxt;
         prdata <= rdata_nxt;
      end
   end

   // Fault pin low while any condition is live
   assign fault_n = ~|live;
   assign irq = |(status_r & mask_r);

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   fault_pin_live_a: assert property (fault_n == !(|live)) else $error("fault pin mismatch");
   level_off_a: assert property ((cfg_r[4:3] == 2'b00 || cfg_r[4:3] == 2'b11) |-> !fault_n &&
      !internal_amp_enable && !preamp_monitor_enable) else $error("bad level not faulted");
   ext_amp_route_a: assert property (exciter_path_enable && cfg_r[12] |-> preamp_monitor_enable &&
      !internal_amp_enable) else $error("routing wrong");
   crit_off_a: assert property (clk_en && (crit_ov_f || crit_uv_f) |=> !boost_enable)
      else $error("boost not disabled");
   uv_off_a: assert property (clk_en && crit_uv_f |=> bst_r == BST_OFF) else $error("uv");
   startup_mask_a: assert property (!lim_live |-> bst_r != BST_SKIP && bst_r != BST_HOLD)
      else $error("limit acted during start-up");
   skip_no_switch_a: assert property (bst_r == BST_SKIP |-> !boost_switch)
      else $error("switch on while skipping");
   lower_cut_a: assert property (lim_live && ilo_f |-> !boost_switch)
      else $error("switch on at lower limit");
   ov_flag_a: assert property (clk_en && ov_f |=> status_r[`ST_BOOST_OV])
      else $error("overvoltage flag lost");
   dac_balance_a: assert property (dac_pos + dac_neg == 10'h200)
      else $error("dac not balanced");

   run_c: cover property (bst_r == BST_RUN && boost_switch);
   skip_c: cover property (bst_r == BST_SKIP);
   hold_c: cover property (bst_r == BST_HOLD);
   irq_c: cover property (irq);
endmodule

/* boost_plant_model.sv */
// Behavioural boost regulator, load and sense comparators
`timescale 1ns/1ps

module boost_plant_model (
   input wire logic pclk,
   input wire logic boost_enable,
   input wire logic [4:0] fault_cmd,
   output logic boost_ov_cmp,
   output logic boost_crit_ov_cmp,
   output logic boost_crit_uv_cmp,
   output logic ilim_lower_cmp,
   output logic ilim_upper_cmp
);
   logic [4:0] sense_r = 5'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Supply off means no output voltage and no coil current to sense
   always_ff @(posedge pclk) begin
      sense_r <= boost_enable ? fault_cmd : 5'h00;
   end

   // Comparator levels toward the device
   assign boost_ov_cmp = sense_r[0];
   assign boost_crit_ov_cmp = sense_r[1];
   assign boost_crit_uv_cmp = sense_r[2];
   assign ilim_lower_cmp = sense_r[3];
   assign ilim_upper_cmp = sense_r[4];
endmodule

/* exciter_drive_control_tb.sv */
// Self-checking bench for the exciter drive control block
`timescale 1ns/1ps
`include "exciter_drive_defines.svh"

module exciter_drive_control_tb;
   import exciter_drive_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, boost_switch, boost_enable, high_current_boost_select;
   logic exciter_path_enable, preamp_monitor_enable, internal_amp_enable, fault_n, irq;
   logic boost_ov_cmp, boost_crit_ov_cmp, boost_crit_uv_cmp, ilim_lower_cmp, ilim_upper_cmp;
   logic [1:0] supply_voltage_select, exciter_level_select, sup;
   logic [2:0] preamp_gain_select, g;
   logic [3:0] common_mode_offset_select, off;
   dac_word_t dac_pos, dac_neg, v;
   logic [4:0] fault_cmd = 5'h00;
   logic [65:0] exp_q[$];
   logic [65:0] e;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   int n, best;
   time t0;

   exciter_drive_control #(.HOLDOFF_CYCLES(50)) exciter_drive_control_i (.pclk, .presetn,
      .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .boost_ov_cmp, .boost_crit_ov_cmp, .boost_crit_uv_cmp, .ilim_lower_cmp,
      .ilim_upper_cmp, .boost_switch, .boost_enable, .supply_voltage_select,
      .high_current_boost_select, .exciter_level_select, .exciter_path_enable, .dac_pos,
      .dac_neg, .preamp_gain_select, .common_mode_offset_select, .preamp_monitor_enable,
      .internal_amp_enable, .fault_n, .irq);

   boost_plant_model boost_plant_model_i (.pclk, .boost_enable, .fault_cmd, .boost_ov_cmp,
      .boost_crit_ov_cmp, .boost_crit_uv_cmp, .ilim_lower_cmp, .ilim_upper_cmp);

   ////////////////////////////////////////////////////////////////////////////////
   // Clock
   initial forever #4 pclk = ~pclk;

   task automatic chk(input string what, input logic [32:0] ex, input logic [32:0] got);
      n_compared++;
      if (got !== ex) begin
         miscompares++;
         $display("Error %s expected %0h seen %0h", what, ex, got);
      end
   endtask

   task automatic close_out;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // APB master: setup, access held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   // Read with expected {pslverr, data} and a compare mask
   task automatic rd(input logic [11:0] a, input logic [32:0] ex,
         input logic [32:0] m = {33{1'b1}});
      exp_q.push_back({m, ex});
      apb(1'b0, a, 32'h0000_0000);
   endtask

   function automatic logic [31:0] cfg(input logic [1:0] s, input logic h, input logic [1:0] l,
         input logic [2:0] f, input logic [3:0] o, input logic x, input logic b);
      return {18'h0, b, x, o, f, l, h, s};
   endfunction

   task automatic sw_period;
      @(posedge boost_switch);
      t0 = $time;
      @(posedge boost_switch);
      n = int'(($time - t0) / 8);
      chk("switch_period_in_band", 33'h1, 33'(n >= 269 && n <= 329));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Monitor: read completions against queue, DAC balance, timeout
   always @(posedge pclk) begin
      cycles++;
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         chk("read", e[32:0], {pslverr, prdata} & e[65:33]);
      end
      if (presetn)
         chk("dac_sum", 33'h200, 33'({1'b0, dac_pos} + {1'b0, dac_neg}));
      if (cycles == 90000) begin
         miscompares++;
         close_out();
      end
   end

   // Main sequence
   initial begin
      void'($urandom(32'hBE0B));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(`OFS_CONFIG, {1'b0, `CFG_RESET});
      rd(`OFS_GAIN, 33'h0);
      rd(12'h0FC, 33'h1_0000_0000);
      chk("fault_n_reset", 33'h0, fault_n);
      sup = 2'h0;
      off = 4'($urandom);
      for (int l = 0; l < 4; l++) begin
         wr(`OFS_CONFIG, cfg(2'h2, 1'b0, 2'(l), 3'h0, off, l[0], 1'b0));
         repeat (4) @(posedge pclk);
         chk("path_enable", 33'(l == 1 || l == 2), exciter_path_enable);
         chk("fault_n", 33'(l == 1 || l == 2), fault_n);
         chk("monitor_en", 33'(l == 1), preamp_monitor_enable);
         chk("int_amp_en", 33'(l == 2), internal_amp_enable);
         chk("offset", 33'(off), common_mode_offset_select);
         chk("level", 33'(l), exciter_level_select);
      end
      wr(`OFS_MASK, 32'h0000_0000);
      chk("irq_masked", 33'h0, irq);
      wr(`OFS_MASK, 32'h0000_0040);
      @(posedge pclk);
      chk("irq_raised", 33'h1, irq);
      rd(`OFS_STATUS, 33'h040);
      wr(`OFS_CONFIG, cfg(2'h2, 1'b0, 2'h1, 3'h0, off, 1'b0, 1'b0));
      rd(`OFS_STATUS, 33'h040);
      rd(`OFS_STATUS, 33'h000);
      @(posedge pclk);
      chk("irq_cleared", 33'h0, irq);
      g = 3'($urandom);
      wr(`OFS_GAIN, 32'hFFFF_FFF8 | 32'(g));
      rd(`OFS_GAIN, 33'(g));
      chk("gain", 33'(g), preamp_gain_select);
      for (int c = 0; c < 8; c++) begin
         wr(`OFS_CONFIG, cfg(2'h1, 1'b0, 2'h1, 3'(c), 4'h0, 1'b0, 1'b0));
         @(dac_pos);
         best = 1000;
         repeat (3) begin
            n = 0;
            v = dac_pos;
            while (dac_pos === v && n < 500) begin
               @(posedge pclk);
               n++;
            end
            if (n < best)
               best = n;
         end
         chk("sample_div", 33'(196 - 12 * c), 33'(best));
      end
      // Clock enable low freezes the sine sequencer
      @(posedge pclk);
      clk_en <= 1'b0;
      @(posedge pclk);
      v = dac_pos;
      repeat (300) @(posedge pclk);
      chk("dac_frozen", 33'(v), 33'(dac_pos));
      clk_en <= 1'b1;
      // Boost start with lower limit present from the first cycle
      fault_cmd <= 5'h08;
      sup = 2'($urandom);
      wr(`OFS_CONFIG, cfg(sup, 1'b1, 2'h1, 3'h0, 4'h0, 1'b0, 1'b1));
      @(posedge pclk);
      chk("supply_sel", 33'(sup), supply_voltage_select);
      chk("hi_current", 33'h1, high_current_boost_select);
      repeat (1500) @(posedge pclk);
      rd(`OFS_STATUS, 33'h000, 33'h018);
      repeat (2500) @(posedge pclk);
      rd(`OFS_STATUS, 33'h008, 33'h008);
      n = 0;
      repeat (400) begin
         @(posedge pclk);
         n += boost_switch;
      end
      chk("switch_held_low", 33'h0, 33'(n));
      fault_cmd <= 5'h00;
      repeat (800) @(posedge pclk);
      repeat (4) sw_period();
      // Upper limit: skips, retries, then the 50-cycle hold
      fault_cmd <= 5'h10;
      repeat (6000) @(posedge pclk);
      rd(`OFS_STATUS, 33'h030, 33'h030);
      fault_cmd <= 5'h00;
      repeat (800) @(posedge pclk);
      rd(`OFS_STATUS, 33'h010, 33'h05F);
      rd(`OFS_STATUS, 33'h000);
      // Short overvoltage pulse is filtered, a long one latches
      fault_cmd <= 5'h01;
      repeat (300) @(posedge pclk);
      fault_cmd <= 5'h00;
      repeat (800) @(posedge pclk);
      rd(`OFS_STATUS, 33'h000, 33'h001);
      fault_cmd <= 5'h01;
      repeat (800) @(posedge pclk);
      chk("ov_fault_n", 33'h0, fault_n);
      chk("ov_boost_on", 33'h1, boost_enable);
      rd(`OFS_STATUS, 33'h001, 33'h001);
      fault_cmd <= 5'h00;
      repeat (800) @(posedge pclk);
      chk("fault_n_clear", 33'h1, fault_n);
      // Critical over and under voltage shut the supply down
      for (int k = 1; k < 3; k++) begin
         fault_cmd <= 5'(1 << k);
         repeat (800) @(posedge pclk);
         chk("crit_boost_off", 33'h0, boost_enable);
         rd(`OFS_STATUS, 33'(1 << k), 33'(1 << k));
         fault_cmd <= 5'h00;
         wr(`OFS_CONFIG, cfg(sup, 1'b0, 2'h1, 3'h0, 4'h0, 1'b0, 1'b0));
         wr(`OFS_CONFIG, cfg(sup, 1'b0, 2'h1, 3'h0, 4'h0, 1'b0, 1'b1));
         repeat (800) @(posedge pclk);
      end
      close_out();
   end
endmodule
